// >>> rtl/wfam_defines.svh
// Constants for the data flash access-mode controller
`ifndef WFAM_DEFINES_SVH
`define WFAM_DEFINES_SVH

// ----------------------------------------------------------------
// Array layout
// ----------------------------------------------------------------
`define WFAM_ADDR_W 15
`define WFAM_SECTOR_LSB 13
`define WFAM_SECTOR_MSB 14
`define WFAM_SECTOR_COUNT 4
`define WFAM_HALF_SEL_BIT 1

// ----------------------------------------------------------------
// Mode select
// ----------------------------------------------------------------
`define WFAM_MODE_ROM 1'h1
`define WFAM_MODE_PROG 1'h0
`define WFAM_MODE_RESET `WFAM_MODE_ROM

// ----------------------------------------------------------------
// Read wait states by bus frequency in MHz
// ----------------------------------------------------------------
`define WFAM_FREQ_LIM0 8'h28
`define WFAM_FREQ_LIM1 8'h48
`define WFAM_FREQ_LIM2 8'h78
`define WFAM_WAIT_LIM0 3'h0
`define WFAM_WAIT_LIM1 3'h2
`define WFAM_WAIT_LIM2 3'h4
`define WFAM_WAIT_LIM3 3'h6

`endif

// >>> rtl/wfam_pkg.sv
// Types and shared decode for the data flash access-mode controller
`default_nettype none
`include "wfam_defines.svh"
package wfam_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		WFAM_SIZE_BYTE,
		WFAM_SIZE_HALF,
		WFAM_SIZE_WORD,
		WFAM_SIZE_RSVD
	} wfam_size_t;

	typedef enum {
		WFAM_IDLE,
		WFAM_ARRAY,
		WFAM_WAIT,
		WFAM_RESP
	} wfam_state_t;

	// Wait states for a bus clock of the given frequency in MHz
	function automatic logic [2:0] wfam_wait_count(input logic [7:0] freqMhz);
		logic [2:0] waits;
		waits = `WFAM_WAIT_LIM3;
		if (freqMhz <= `WFAM_FREQ_LIM0) begin
			waits = `WFAM_WAIT_LIM0;
		end else if (freqMhz <= `WFAM_FREQ_LIM1) begin
			waits = `WFAM_WAIT_LIM1;
		end else if (freqMhz <= `WFAM_FREQ_LIM2) begin
			waits = `WFAM_WAIT_LIM2;
		end
		return waits;
	endfunction : wfam_wait_count

endpackage : wfam_pkg
`default_nettype wire

// >>> rtl/wfam_wait_if.sv
// Handshake between the access sequencer and the wait-state counter
`default_nettype none
interface wfam_wait_if;
	logic start;
	logic [2:0] waits;
	logic done;
	modport ctrl(output start, output waits, input done);
	modport gen(input start, input waits, output done);
endinterface : wfam_wait_if
`default_nettype wire

// >>> rtl/wfam_wait_gen.sv
// Read wait-state counter
`default_nettype none
module wfam_wait_gen
	import wfam_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Sequencer side
	wfam_wait_if.gen waitBus
);

	logic [2:0] count;
	logic [2:0] next_count;

	// ----------------------------------------------------------------
	// Countdown
	// ----------------------------------------------------------------
	// Load on start, then count down to zero
	always_comb begin
		next_count = count;
		if (waitBus.start) begin
			next_count = waitBus.waits;
		end else if (count != 3'h0) begin
			next_count = count - 3'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			count <= 3'h0;
		end else begin
			count <= next_count;
		end
	end

	// Done is combinational so zero waits costs no extra cycle
	assign waitBus.done = (count == 3'h0) && !waitBus.start;

endmodule : wfam_wait_gen
`default_nettype wire

// >>> rtl/wfam_access_ctrl.sv
// Access-mode controller for the 32-Kbyte data flash
// ----------------------------------------------------------------
// Overview of operation
// - Four 8-Kbyte sectors, 32 Kbytes total; sector taken from address.
// - Read wait states: 0 to 40, 2 to 72, 4 to 120, 6 to 160 MHz.
// - Select bit one gives read-only mode with word reads and fetches allowed.
// - Read-only mode accepts no command and never writes or erases.
// - Reset forces the select bit back to one, read-only mode.
// - Select bit zero gives programming mode with half-word accesses.
// - Programming mode refuses word accesses and instruction fetches.
// - Programming mode reads return 16-bit half-words.
// - Programming mode half-word writes launch the embedded algorithm.
// - Algorithm erases a sector, erases all, or programs half-words.
// - Read-only mode never returns algorithm status flags.
// ----------------------------------------------------------------
`default_nettype none
`include "wfam_defines.svh"
module wfam_access_ctrl
	import wfam_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Configuration
	input wire logic [7:0] busFreqMhz,
	input wire logic sizeCtrlWrite,
	input wire logic sizeCtrlWdata,
	output logic accessSizeSelect,
	// Processor bus
	input wire logic busReq,
	input wire logic busWrite,
	input wire logic busFetch,
	input wire logic [1:0] busSize,
	input wire logic [`WFAM_ADDR_W-1:0] busAddr,
	input wire logic [31:0] busWdata,
	output logic busReady,
	output logic busError,
	output logic [31:0] busRdata,
	// Flash array
	output logic arrRdEn,
	output logic [`WFAM_ADDR_W-1:0] arrAddr,
	output logic [1:0] sectorSel,
	input wire logic [31:0] arrRdata,
	// Embedded algorithm
	input wire logic algBusy,
	input wire logic [7:0] algStatus,
	output logic algCmdWrite,
	output logic [`WFAM_ADDR_W-1:0] algCmdAddr,
	output logic [15:0] algCmdData
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	wfam_state_t state;
	wfam_state_t next_state;
	logic accMode;
	logic next_accMode;
	logic next_accessSizeSelect;
	logic next_busError;
	logic [31:0] next_busRdata;
	logic [`WFAM_ADDR_W-1:0] next_arrAddr;
	logic [1:0] next_sectorSel;
	logic next_algCmdWrite;
	logic [`WFAM_ADDR_W-1:0] next_algCmdAddr;
	logic [15:0] next_algCmdData;
	logic fromStatus;
	logic next_fromStatus;
	logic accept;
	logic refuse;
	logic isCmd;

	wfam_wait_if waitBus();

	wfam_wait_gen u_wait (
		.core_clk(core_clk),
		.srst(srst),
		.waitBus(waitBus)
	);

	// ----------------------------------------------------------------
	// Mode select bit
	// ----------------------------------------------------------------
	// Writes land at once; a running access keeps its own snapshot
	always_comb begin
		next_accessSizeSelect = accessSizeSelect;
		if (sizeCtrlWrite) begin
			next_accessSizeSelect = sizeCtrlWdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			accessSizeSelect <= `WFAM_MODE_RESET;
		end else begin
			accessSizeSelect <= next_accessSizeSelect;
		end
	end

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	// Read-only mode: every write is refused, no command leaves
	// Programming mode: words and fetches refused, byte writes too
	assign accept = (state == WFAM_IDLE) && busReq;
	always_comb begin
		refuse = 1'b0;
		isCmd = 1'b0;
		if (accessSizeSelect == `WFAM_MODE_ROM) begin
			refuse = busWrite;
		end else if (busFetch || (busSize == WFAM_SIZE_WORD) || (busSize == WFAM_SIZE_RSVD)) begin
			refuse = 1'b1;
		end else if (busWrite) begin
			refuse = (busSize != WFAM_SIZE_HALF);
			isCmd = (busSize == WFAM_SIZE_HALF);
		end
	end

	assign waitBus.waits = wfam_wait_count(busFreqMhz);
	assign waitBus.start = (state == WFAM_ARRAY);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_accMode = accMode;
		next_busError = busError;
		next_busRdata = busRdata;
		next_arrAddr = arrAddr;
		next_sectorSel = sectorSel;
		next_algCmdWrite = 1'b0;
		next_algCmdAddr = algCmdAddr;
		next_algCmdData = algCmdData;
		next_fromStatus = fromStatus;
		case (state)
			WFAM_IDLE: begin
				if (accept) begin
					// Mode frozen for the whole access
					next_accMode = accessSizeSelect;
					next_arrAddr = busAddr;
					next_sectorSel = busAddr[`WFAM_SECTOR_MSB:`WFAM_SECTOR_LSB];
					next_busError = refuse;
					next_fromStatus = 1'b0;
					if (refuse) begin
						next_state = WFAM_RESP;
					end else if (isCmd) begin
						// Sector erase, full erase or half-word program
						next_algCmdWrite = 1'b1;
						next_algCmdAddr = busAddr;
						next_algCmdData = busWdata[15:0];
						next_state = WFAM_RESP;
					end else begin
						next_state = WFAM_ARRAY;
					end
				end
			end
			WFAM_ARRAY: begin
				next_state = WFAM_WAIT;
			end
			WFAM_WAIT: begin
				if (waitBus.done) begin
					next_state = WFAM_RESP;
					if (accMode == `WFAM_MODE_ROM) begin
						// Whole word, flags never shown here
						next_busRdata = arrRdata;
					end else if (algBusy) begin
						next_busRdata = {24'h000000, algStatus};
						next_fromStatus = 1'b1;
					end else if (arrAddr[`WFAM_HALF_SEL_BIT]) begin
						next_busRdata = {16'h0000, arrRdata[31:16]};
					end else begin
						next_busRdata = {16'h0000, arrRdata[15:0]};
					end
				end
			end
			WFAM_RESP: begin
				next_state = WFAM_IDLE;
			end
			default: begin
				next_state = WFAM_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= WFAM_IDLE;
			accMode <= `WFAM_MODE_RESET;
			busError <= 1'b0;
			busRdata <= 32'h00000000;
			arrAddr <= '0;
			sectorSel <= 2'h0;
			algCmdWrite <= 1'b0;
			algCmdAddr <= '0;
			algCmdData <= 16'h0000;
			fromStatus <= 1'b0;
		end else begin
			state <= next_state;
			accMode <= next_accMode;
			busError <= next_busError;
			busRdata <= next_busRdata;
			arrAddr <= next_arrAddr;
			sectorSel <= next_sectorSel;
			algCmdWrite <= next_algCmdWrite;
			algCmdAddr <= next_algCmdAddr;
			algCmdData <= next_algCmdData;
			fromStatus <= next_fromStatus;
		end
	end

	// Handshake outputs decoded from state
	assign busReady = (state == WFAM_RESP);
	assign arrRdEn = (state == WFAM_ARRAY);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence seqReadAccept(logic [7:0] lo, logic [7:0] hi);
		accept && !refuse && !isCmd && (busFreqMhz > lo) && (busFreqMhz <= hi);
	endsequence

	sequence seqOkReply;
		busReady && !busError;
	endsequence

	AST_RESET_ROM: assert property (@(posedge core_clk) disable iff (1'b0)
		srst |=> accessSizeSelect == `WFAM_MODE_ROM)
		else $error("mode bit not forced to read-only by reset");

	AST_ROM_NO_CMD: assert property (
		(accept && busWrite && accessSizeSelect) |=> busReady && busError && !algCmdWrite)
		else $error("write in read-only mode not refused");

	AST_PROG_CMD: assert property (
		(accept && busWrite && !accessSizeSelect && !busFetch && busSize == WFAM_SIZE_HALF)
		|=> algCmdWrite && busReady && !busError && algCmdData == $past(busWdata[15:0]))
		else $error("half-word command not launched");

	AST_PROG_NO_WORD: assert property (
		(accept && !accessSizeSelect && (busFetch || busSize == WFAM_SIZE_WORD))
		|=> busReady && busError)
		else $error("word or fetch served in programming mode");

	AST_WAIT_FAST: assert property (
		seqReadAccept(8'h00, 8'h28) |=> !busReady [*2] ##1 seqOkReply)
		else $error("zero-wait read latency wrong");

	AST_WAIT_SLOW: assert property (
		seqReadAccept(8'h78, 8'hA0) |=> !busReady [*8] ##1 seqOkReply)
		else $error("six-wait read latency wrong");

	AST_ROM_READ: assert property (
		(accept && accessSizeSelect && !busWrite) |-> ##[3:9] seqOkReply)
		else $error("read-only word read or fetch not served");

	AST_HALF_DATA: assert property (
		(busReady && !accMode && !busError && !algCmdWrite) |-> busRdata[31:16] == 16'h0000)
		else $error("programming-mode read wider than a half-word");

	AST_ROM_NO_STATUS: assert property (
		(busReady && accMode && !busError) |-> !fromStatus && busRdata == $past(arrRdata))
		else $error("status flags shown in read-only mode");

	AST_SECTOR: assert property (
		accept |=> sectorSel == $past(busAddr[`WFAM_SECTOR_MSB:`WFAM_SECTOR_LSB]))
		else $error("sector select does not follow address");

	AST_MODE_FROZEN: assert property (
		(state != WFAM_IDLE) |=> $stable(accMode) || $past(state) == WFAM_IDLE)
		else $error("access mode changed mid access");

	// A served read strobes the array exactly once; refusals and commands never do
	sequence seqArrayRead;
		arrRdEn ##1 !arrRdEn;
	endsequence

	AST_ARRAY_STROBE: assert property (
		(accept && !refuse && !isCmd) |=> seqArrayRead)
		else $error("array read strobe not a single pulse");

	AST_NO_ARRAY_STROBE: assert property (
		(accept && (refuse || isCmd)) |=> !arrRdEn)
		else $error("array read started for a refused access or command");

	AST_CMD_PROG_ONLY: assert property (
		algCmdWrite |-> (accMode == `WFAM_MODE_PROG))
		else $error("command launched outside programming mode");

	AST_CMD_SINGLE: assert property (
		algCmdWrite |=> !algCmdWrite)
		else $error("one half-word write launched more than one command");

	AST_PROG_HALF_READ: assert property (
		(accept && !accessSizeSelect && !busWrite && !busFetch && busSize == WFAM_SIZE_HALF)
		|-> ##[3:9] seqOkReply)
		else $error("half-word read in programming mode not served");

	AST_MODE_SNAPSHOT: assert property (
		accept |=> accMode == $past(accessSizeSelect))
		else $error("access mode not taken from the select bit at accept");

endmodule : wfam_access_ctrl
`default_nettype wire

// >>> tb/wfam_flash_model.sv
// Array and embedded-algorithm stand-in behind the access controller
`default_nettype none
`include "wfam_defines.svh"
module wfam_flash_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Array
	input wire logic [`WFAM_ADDR_W-1:0] arrAddr,
	output logic [31:0] arrRdata,
	// Algorithm
	input wire logic algCmdWrite,
	output logic algBusy,
	output logic [7:0] algStatus,
	output logic [7:0] cmdCount
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] busyLeft;
	// Address pattern in both halves, so a wrong half or width shows
	assign arrRdata = {1'b0, arrAddr, 1'b1, arrAddr};
	assign algStatus = 8'hA5;
	assign algBusy = (busyLeft != 4'h0);
	// Each command keeps the algorithm busy long enough for a status read
	always_ff @(posedge core_clk) begin
		if (srst) begin
			busyLeft <= 4'h0;
			cmdCount <= 8'h00;
		end else if (algCmdWrite) begin
			busyLeft <= 4'hC;
			cmdCount <= cmdCount + 8'h01;
		end else if (busyLeft != 4'h0) begin
			busyLeft <= busyLeft - 4'h1;
		end
	end
endmodule : wfam_flash_model
`default_nettype wire

// >>> tb/wfam_access_ctrl_test.sv
// Self-checking bench for the data flash access-mode controller
`default_nettype none
module wfam_access_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, srst, sizeCtrlWrite, sizeCtrlWdata, accessSizeSelect;
	logic busReq, busWrite, busFetch, busReady, busError, arrRdEn, algBusy, algCmdWrite;
	logic [7:0] busFreqMhz, algStatus, cmdCount;
	logic [1:0] busSize, sectorSel;
	logic [14:0] busAddr, arrAddr, algCmdAddr, cmdAd;
	logic [31:0] busWdata, busRdata, arrRdata;
	logic [15:0] algCmdData, cmdDat;
	logic err, cmdSeen;
	logic [31:0] rd;
	int lat, num_errors, n_compared, rdStrobes;
	wfam_access_ctrl dut_u (.core_clk(core_clk), .srst(srst), .busFreqMhz(busFreqMhz),
		.sizeCtrlWrite(sizeCtrlWrite), .sizeCtrlWdata(sizeCtrlWdata),
		.accessSizeSelect(accessSizeSelect), .busReq(busReq), .busWrite(busWrite),
		.busFetch(busFetch), .busSize(busSize), .busAddr(busAddr), .busWdata(busWdata),
		.busReady(busReady), .busError(busError), .busRdata(busRdata), .arrRdEn(arrRdEn),
		.arrAddr(arrAddr), .sectorSel(sectorSel), .arrRdata(arrRdata), .algBusy(algBusy),
		.algStatus(algStatus), .algCmdWrite(algCmdWrite), .algCmdAddr(algCmdAddr),
		.algCmdData(algCmdData));
	wfam_flash_model model_u (.core_clk(core_clk), .srst(srst), .arrAddr(arrAddr),
		.arrRdata(arrRdata), .algCmdWrite(algCmdWrite), .algBusy(algBusy),
		.algStatus(algStatus), .cmdCount(cmdCount));
	// Free-running bus clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// One bus access; the request stands until the reply, then a gap cycle
	task automatic access(input logic wr, input logic fe, input logic [1:0] sz,
		input logic [14:0] ad, input logic [15:0] wd);
		int n;
		n = 0;
		rdStrobes = 0;
		busWrite = wr;
		busFetch = fe;
		busSize = sz;
		busAddr = ad;
		busWdata = {16'hFFFF, wd};
		busReq = 1'b1;
		while (busReady !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			#10;
			n++;
			if (arrRdEn === 1'b1) begin
				rdStrobes++;
			end
		end
		if (n >= 20) begin
			num_errors++;
			$display("wrong value at %0t: no bus reply", $time);
			print_verdict();
		end
		err = busError;
		rd = busRdata;
		lat = n;
		cmdSeen = algCmdWrite;
		cmdAd = algCmdAddr;
		cmdDat = algCmdData;
		@(posedge core_clk);
		#10;
		busReq = 1'b0;
		@(posedge core_clk);
		#10;
	endtask : access
	// Mode-bit write pulse
	task automatic set_mode(input logic b);
		sizeCtrlWdata = b;
		sizeCtrlWrite = 1'b1;
		@(posedge core_clk);
		#10;
		sizeCtrlWrite = 1'b0;
	endtask : set_mode
	task automatic do_reset();
		srst = 1'b1;
		repeat (6) @(posedge core_clk);
		#10;
		srst = 1'b0;
	endtask : do_reset
	// Word reads and fetches in read-only mode at every wait-state band edge
	task automatic test_rom_reads();
		logic [7:0] fq[7] = '{8'h28, 8'h29, 8'h48, 8'h49, 8'h78, 8'h79, 8'hA0};
		int wt[7] = '{0, 2, 2, 4, 4, 6, 6};
		logic [14:0] ad;
		chk(accessSizeSelect, 32'h1, "mode after reset");
		for (int i = 0; i < 7; i++) begin
			busFreqMhz = fq[i];
			ad = {i[1:0], 13'h0AB4};
			access(1'b0, i[0], 2'h2, ad, 16'h0000);
			chk(rd, {1'b0, ad, 1'b1, ad}, "word read");
			chk(err, 32'h0, "read error");
			chk(lat, wt[i] + 3, "read latency");
			chk(sectorSel, i % 4, "sector");
			chk(rdStrobes, 1, "array strobe");
		end
		busFreqMhz = 8'h28;
		$display("test rom reads done");
	endtask : test_rom_reads
	// Writes in read-only mode are refused and launch nothing
	task automatic test_rom_write();
		access(1'b1, 1'b0, 2'h1, 15'h2AA8, 16'h00AA);
		chk({err, cmdSeen, cmdCount}, {2'b10, 8'h00}, "refused write");
		chk(lat, 1, "refuse latency");
		chk(rdStrobes, 0, "no array strobe");
		$display("test rom write done");
	endtask : test_rom_write
	// Half-word reads, refusals and commands in programming mode
	task automatic test_prog();
		logic [15:0] cd[4] = '{16'h00AA, 16'h0055, 16'h0080, 16'h0030};
		set_mode(1'b0);
		chk(accessSizeSelect, 32'h0, "prog mode");
		access(1'b0, 1'b0, 2'h1, 15'h4000, 16'h0000);
		chk(rd, {16'h0000, 1'b1, 15'h4000}, "low half");
		access(1'b0, 1'b0, 2'h1, 15'h4002, 16'h0000);
		chk(rd, {16'h0, 1'b0, 15'h4002}, "high half");
		access(1'b0, 1'b0, 2'h2, 15'h4000, 16'h0000);
		chk(err, 32'h1, "word refused");
		access(1'b0, 1'b1, 2'h1, 15'h4000, 16'h0000);
		chk(err, 32'h1, "fetch refused");
		access(1'b0, 1'b0, 2'h0, 15'h4002, 16'h0000);
		chk(rd, {16'h0000, 1'b0, 15'h4002}, "byte read");
		access(1'b1, 1'b0, 2'h0, 15'h0AA8, 16'h00AA);
		chk({err, cmdSeen}, 32'h2, "byte write refused");
		access(1'b0, 1'b0, 2'h3, 15'h4000, 16'h0000);
		chk(err, 32'h1, "size 3 refused");
		chk(cmdCount, 32'h0, "no command yet");
		for (int i = 0; i < 4; i++) begin
			access(1'b1, 1'b0, 2'h1, {i[1:0], 13'h0AA8}, cd[i]);
			chk({err, cmdSeen, cmdAd}, {2'b01, i[1:0], 13'h0AA8}, "cmd addr");
			chk(cmdDat, cd[i], "cmd data");
		end
		access(1'b0, 1'b0, 2'h1, 15'h0000, 16'h0000);
		chk(rd, 32'h000000A5, "status read");
		$display("test prog done");
	endtask : test_prog
	// Mode change takes effect at once; status never shows in read-only mode
	task automatic test_switch();
		access(1'b1, 1'b0, 2'h1, 15'h2AA8, 16'h00F0);
		set_mode(1'b1);
		access(1'b0, 1'b0, 2'h2, 15'h1234, 16'h0000);
		chk(rd, {1'b0, 15'h1234, 1'b1, 15'h1234}, "rom read busy");
		chk(err, 32'h0, "rom read busy error");
		chk(cmdCount, 32'h5, "commands");
		set_mode(1'b0);
		do_reset();
		chk(accessSizeSelect, 32'h1, "mode after re-reset");
		access(1'b1, 1'b0, 2'h1, 15'h2AA8, 16'h00AA);
		chk({err, cmdSeen}, 32'h2, "write after reset");
		$display("test switch done");
	endtask : test_switch
	initial begin
		num_errors = 0;
		n_compared = 0;
		busFreqMhz = 8'h28;
		sizeCtrlWrite = 1'b0;
		sizeCtrlWdata = 1'b1;
		busReq = 1'b0;
		busWrite = 1'b0;
		busFetch = 1'b0;
		busSize = 2'h2;
		busAddr = 15'h0000;
		busWdata = 32'h00000000;
		do_reset();
		test_rom_reads();
		test_rom_write();
		test_prog();
		test_switch();
		print_verdict();
	end
endmodule : wfam_access_ctrl_test
`default_nettype wire
